// ---- design/pca_compare.sv ----
// Counter array with compare, PWM, frequency output and watchdog modes
//
// Added by the designer: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
// Function
// - Software timer: 16-bit equality with compare sets match flag, raises interrupt if enabled.
// - Match flag stays set until software clears it.
// - Software timer runs with compare-enable and match-enable both set.
// - Compare low write clears compare-enable; compare high write sets it.
// - High-speed output toggles pin on each 16-bit match.
// - Entering high-speed output mode sets the toggle output to 1.
// - Frequency mode: low byte match toggles pin and adds high byte to low.
// - Frequency mode high byte zero gives 256 counter clock half-period.
// - Frequency mode runs with compare-enable, toggle and pulse-width set.
// - 8-bit PWM: high on low byte match, low on low byte overflow.
// - 8-bit PWM reloads compare low from compare high on low byte wrap.
// - 8-bit PWM with compare-enable and pulse-width set, wide select clear.
// - PWM with compare-enable clear has no matches, output stays low.
// - 16-bit PWM: high on full match, low on counter overflow.
// - Watchdog uses module 2: high byte versus counter high, low byte offset.
// - Reset enables watchdog, timebase divide by 12, counter and offset zero.
// - Watchdog forces counter on, freezes counter writes, forces module 2 timer mode.
// - Run control writes don't affect counter under watchdog; reads software value.
// - Module 2 high write under watchdog loads counter high plus offset.
// - Watchdog reset on low overflow at high match, or writing 1 to flag 2.
// - Enable or lock turns watchdog on; lock holds it until reset.
// - Run control starts and stops counter when watchdog is off.
module pca_compare
  import pca_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              cpu_idle,
  input  wire logic              timer0_overflow,
  input  wire logic              eci_pin,
  input  wire logic              ext_clk_pin,
  output logic      [NMOD-1:0]   module_output_pin,
  output logic                   pca_irq,
  output logic                   watchdog_reset_req
);

  typedef struct packed {
    logic [15:0]           cnt;
    logic [3:0]            pre;
    logic [7:0]            snap;
    logic [NMOD-1:0][7:0]  cmp_lo;
    logic [NMOD-1:0][7:0]  cmp_hi;
    logic [NMOD-1:0][7:0]  mmode;
    logic [NMOD-1:0]       match_flag;
    logic                  cf;
    logic                  counter_run;
    logic [7:0]            amode;
    logic [NMOD-1:0]       hso_prev;
    logic [NMOD-1:0]       pin;
    logic [2:0]            eci_sync;
    logic [2:0]            ext_sync;
    logic [2:0]            ext_div;
    logic                  waitreq;
    logic [31:0]           rdata;
    logic                  irq;
    logic                  wdt_rst;
  } state_s;

  state_s state_reg;
  state_s state_next;

  // ==========================================================
  // Next state
  always_comb
  begin
    logic        wd_on;
    logic        req;
    logic        wr;
    logic [7:0]  wdata;
    logic        src;
    logic        tick;
    logic        low_ovf;
    logic [15:0] inc;
    logic [7:0]  m;
    logic        fm;
    logic        lm;
    logic        hso;
    logic [2:0]  tb;
    int          idx;
    wd_on = 1'b0;
    req = 1'b0;
    wr = 1'b0;
    wdata = 8'h00;
    src = 1'b0;
    tick = 1'b0;
    low_ovf = 1'b0;
    inc = 16'h0000;
    m = 8'h00;
    fm = 1'b0;
    lm = 1'b0;
    hso = 1'b0;
    tb = 3'h0;
    idx = 0;
    state_next = state_reg;
    state_next.wdt_rst = 1'b0;
    wd_on = state_reg.amode[MD_WATCHDOG_ENABLE] | state_reg.amode[MD_WATCHDOG_LOCK];

    // ========================================================
    // Timebase
    state_next.pre = (state_reg.pre == PRE_LAST) ? 4'h0 : state_reg.pre + 4'h1;
    state_next.eci_sync = {state_reg.eci_sync[1:0], eci_pin};
    state_next.ext_sync = {state_reg.ext_sync[1:0], ext_clk_pin};
    if (state_reg.ext_sync[1] && !state_reg.ext_sync[2])
    begin
      state_next.ext_div = state_reg.ext_div + 3'h1;
    end
    tb = state_reg.amode[MD_TBHI:MD_TBLO];
    case (tb)
      TB_DIV12: src = (state_reg.pre == PRE_LAST);
      TB_DIV4:  src = (state_reg.pre[1:0] == DIV4_LAST);
      TB_T0:    src = timer0_overflow;
      TB_ECI:   src = !state_reg.eci_sync[1] && state_reg.eci_sync[2];
      TB_SYS:   src = 1'b1;
      TB_EXT8:  src = state_reg.ext_sync[1] && !state_reg.ext_sync[2]
                      && (state_reg.ext_div == EXT_LAST);
      default:  src = 1'b0;
    endcase
    tick = src && (wd_on || state_reg.counter_run)
           && !(state_reg.amode[MD_IDLE] && cpu_idle);
    inc = state_reg.cnt + 16'h0001;
    low_ovf = tick && (state_reg.cnt[7:0] == BYTE_MAX);

    // ========================================================
    // Register bus
    req = (avs_read || avs_write) && state_reg.waitreq;
    state_next.waitreq = !req;
    wr = req && avs_write && avs_byteenable[0];
    wdata = avs_writedata[7:0];
    if (req && avs_read)
    begin
      state_next.rdata = 32'h00000000;
      case (avs_address)
        ADDR_CTRL: state_next.rdata[7:0] = {state_reg.cf, state_reg.counter_run,
                                            3'h0, state_reg.match_flag};
        ADDR_MODE: state_next.rdata[7:0] = state_reg.amode;
        ADDR_CNTL:
        begin
          state_next.rdata[7:0] = state_reg.cnt[7:0];
          state_next.snap = state_reg.cnt[15:8];
        end
        ADDR_CNTH: state_next.rdata[7:0] = state_reg.snap;
        default:
        begin
          for (int i = 0; i < NMOD; i++)
          begin
            if (avs_address == ADDR_MMODE + 4'(i))
            begin
              state_next.rdata[7:0] = state_reg.mmode[i];
            end
            if (avs_address == ADDR_CMPL + 4'(i))
            begin
              state_next.rdata[7:0] = state_reg.cmp_lo[i];
            end
            if (avs_address == ADDR_CMPH + 4'(i))
            begin
              state_next.rdata[7:0] = state_reg.cmp_hi[i];
            end
          end
        end
      endcase
    end
    if (wr)
    begin
      case (avs_address)
        ADDR_CTRL:
        begin
          state_next.cf = wdata[CTRL_CF];
          state_next.counter_run = wdata[CTRL_RUN];
          state_next.match_flag = wdata[NMOD-1:0];
          if (wd_on && wdata[WD_MOD])
          begin
            state_next.wdt_rst = 1'b1;
          end
        end
        ADDR_MODE:
        begin
          if (wd_on)
          begin
            if (!state_reg.amode[MD_WATCHDOG_LOCK])
            begin
              state_next.amode[MD_WATCHDOG_ENABLE] = wdata[MD_WATCHDOG_ENABLE];
            end
          end
          else
          begin
            state_next.amode = wdata & MODE_MASK;
          end
          state_next.amode[MD_WATCHDOG_LOCK] = state_reg.amode[MD_WATCHDOG_LOCK] | wdata[MD_WATCHDOG_LOCK];
        end
        ADDR_CNTL:
        begin
          if (!wd_on)
          begin
            state_next.cnt[7:0] = wdata;
          end
        end
        ADDR_CNTH:
        begin
          if (!wd_on)
          begin
            state_next.cnt[15:8] = wdata;
          end
        end
        default:
        begin
          for (int i = 0; i < NMOD; i++)
          begin
            if (!(wd_on && i == WD_MOD))
            begin
              if (avs_address == ADDR_MMODE + 4'(i))
              begin
                state_next.mmode[i] = wdata;
              end
              if (avs_address == ADDR_CMPL + 4'(i))
              begin
                state_next.cmp_lo[i] = wdata;
                state_next.mmode[i][MM_ECOM] = 1'b0;
              end
              if (avs_address == ADDR_CMPH + 4'(i))
              begin
                state_next.cmp_hi[i] = wdata;
                state_next.mmode[i][MM_ECOM] = 1'b1;
              end
            end
            else
            begin
              if (avs_address == ADDR_CMPL + 4'(i))
              begin
                state_next.cmp_lo[i] = wdata;
              end
              if (avs_address == ADDR_CMPH + 4'(i))
              begin
                state_next.cmp_hi[i] = state_reg.cnt[15:8] + state_reg.cmp_lo[i];
              end
            end
          end
        end
      endcase
    end

    // ========================================================
    // Counter and modules; hardware sets win over bus clears
    if (tick)
    begin
      state_next.cnt = inc;
      if (state_reg.cnt == CNT_MAX)
      begin
        state_next.cf = 1'b1;
      end
    end
    for (int i = 0; i < NMOD; i++)
    begin
      m = state_reg.mmode[i];
      if (wd_on && i == WD_MOD)
      begin
        m = MM_FORCE_SWT;
      end
      fm = tick && m[MM_ECOM] && (inc == {state_reg.cmp_hi[i], state_reg.cmp_lo[i]});
      lm = tick && m[MM_ECOM] && (inc[7:0] == state_reg.cmp_lo[i]);
      hso = m[MM_ECOM] && m[MM_MAT] && m[MM_TOG] && !m[MM_PWM];
      state_next.hso_prev[i] = hso;
      if (fm && m[MM_MAT] && !(wd_on && i == WD_MOD))
      begin
        state_next.match_flag[i] = 1'b1;
      end
      if (hso)
      begin
        if (!state_reg.hso_prev[i])
        begin
          state_next.pin[i] = 1'b1;
        end
        else if (fm)
        begin
          state_next.pin[i] = !state_reg.pin[i];
        end
      end
      else if (m[MM_PWM] && m[MM_TOG])
      begin
        if (m[MM_ECOM] && lm)
        begin
          state_next.pin[i] = !state_reg.pin[i];
          // A zero step leaves the low byte, so the next match is 256 clocks out
          state_next.cmp_lo[i] = state_reg.cmp_lo[i] + state_reg.cmp_hi[i];
        end
      end
      else if (m[MM_PWM] && m[MM_W16])
      begin
        if (tick && state_reg.cnt == CNT_MAX)
        begin
          state_next.pin[i] = fm;
        end
        else if (fm)
        begin
          state_next.pin[i] = 1'b1;
        end
      end
      else if (m[MM_PWM])
      begin
        if (low_ovf)
        begin
          state_next.cmp_lo[i] = state_reg.cmp_hi[i];
          state_next.pin[i] = m[MM_ECOM] && (state_reg.cmp_hi[i] == 8'h00);
        end
        else if (lm)
        begin
          state_next.pin[i] = 1'b1;
        end
      end
    end

    // ========================================================
    // Watchdog timeout and interrupt request
    if (wd_on && low_ovf && state_reg.cmp_hi[WD_MOD] == state_reg.cnt[15:8])
    begin
      state_next.wdt_rst = 1'b1;
    end
    state_next.irq = (state_reg.cf && state_reg.amode[MD_ECF]);
    for (int i = 0; i < NMOD; i++)
    begin
      idx = i;
      if (state_reg.match_flag[i] && state_reg.mmode[i][MM_ECC]
          && !(wd_on && idx == WD_MOD))
      begin
        state_next.irq = 1'b1;
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state_reg         <= '0;
      state_reg.amode   <= MODE_RST;
      state_reg.waitreq <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign avs_readdata       = state_reg.rdata;
  assign avs_waitrequest    = state_reg.waitreq;
  assign module_output_pin  = state_reg.pin;
  assign pca_irq            = state_reg.irq;
  assign watchdog_reset_req = state_reg.wdt_rst;

endmodule

// ---- design/pca_pkg.sv ----
// Constants for the counter array compare, PWM and watchdog block
package pca_pkg;
  // Avalon word addresses
  localparam logic [3:0] ADDR_CTRL  = 4'h0;
  localparam logic [3:0] ADDR_MODE  = 4'h1;
  localparam logic [3:0] ADDR_MMODE = 4'h2;
  localparam logic [3:0] ADDR_CNTL  = 4'h5;
  localparam logic [3:0] ADDR_CNTH  = 4'h6;
  localparam logic [3:0] ADDR_CMPL  = 4'h7;
  localparam logic [3:0] ADDR_CMPH  = 4'ha;
  localparam int         NMOD       = 3;
  localparam int         WD_MOD     = 2;
  // array_control_reg fields
  localparam int CTRL_CF  = 7;
  localparam int CTRL_RUN = 6;
  // array_mode_reg fields
  localparam int MD_IDLE  = 7;
  localparam int MD_WATCHDOG_ENABLE  = 6;
  localparam int MD_WATCHDOG_LOCK = 5;
  localparam int MD_TBHI  = 3;
  localparam int MD_TBLO  = 1;
  localparam int MD_ECF   = 0;
  localparam logic [7:0] MODE_RST  = 8'h40;
  localparam logic [7:0] MODE_MASK = 8'hef;
  // module_mode_reg fields
  localparam int MM_W16  = 7;
  localparam int MM_ECOM = 6;
  localparam int MM_MAT  = 3;
  localparam int MM_TOG  = 2;
  localparam int MM_PWM  = 1;
  localparam int MM_ECC  = 0;
  localparam logic [7:0] MM_FORCE_SWT = 8'h48;
  // Timebase codes and dividers
  localparam logic [2:0] TB_DIV12 = 3'h0;
  localparam logic [2:0] TB_DIV4  = 3'h1;
  localparam logic [2:0] TB_T0    = 3'h2;
  localparam logic [2:0] TB_ECI   = 3'h3;
  localparam logic [2:0] TB_SYS   = 3'h4;
  localparam logic [2:0] TB_EXT8  = 3'h5;
  localparam logic [3:0] PRE_LAST = 4'hb;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  localparam logic [2:0] EXT_LAST = 3'h7;
  localparam logic [7:0] BYTE_MAX = 8'hff;
  localparam logic [15:0] CNT_MAX = 16'hffff;
endpackage

// ---- tb/pca_compare_chk.sv ----
// Port-level checker for the counter array compare block
`timescale 1ns/1ps
module pca_compare_chk
  import pca_pkg::*;
(
  input wire logic            sys_clk,
  input wire logic            sys_rst,
  input wire logic [3:0]      avs_address,
  input wire logic            avs_read,
  input wire logic            avs_write,
  input wire logic [31:0]     avs_writedata,
  input wire logic [3:0]      avs_byteenable,
  input wire logic [31:0]     avs_readdata,
  input wire logic            avs_waitrequest,
  input wire logic [NMOD-1:0] module_output_pin,
  input wire logic            pca_irq,
  input wire logic            watchdog_reset_req
);
  logic take;
  logic wen;
  logic wd_on;
  logic en_reg;
  logic lk_reg;
  logic run_reg;
  assign take  = (avs_read | avs_write) & avs_waitrequest;
  assign wen   = take & avs_write & avs_byteenable[0];
  assign wd_on = en_reg | lk_reg;
  // Shadow of the software-written enable, lock and run bits
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      en_reg  <= 1'b1;
      lk_reg  <= 1'b0;
      run_reg <= 1'b0;
    end
    else if (wen && avs_address == ADDR_MODE)
    begin
      en_reg <= lk_reg ? en_reg : avs_writedata[MD_WATCHDOG_ENABLE];
      lk_reg <= lk_reg | avs_writedata[MD_WATCHDOG_LOCK];
    end
    else if (wen && avs_address == ADDR_CTRL)
      run_reg <= avs_writedata[CTRL_RUN];
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_answer;
    take |=> !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer)
    else $error("request not answered in one cycle");
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("answer longer than one cycle");
  property p_idle_wait;
    (!avs_read && !avs_write && avs_waitrequest) |=> avs_waitrequest;
  endproperty
  a_idle_wait: assert property (p_idle_wait)
    else $error("answer without request");
  property p_forced;
    (wen && avs_address == ADDR_CTRL && avs_writedata[2] && wd_on) |=> watchdog_reset_req;
  endproperty
  a_forced: assert property (p_forced)
    else $error("flag write did not force reset");
  property p_pulse;
    watchdog_reset_req |=> !watchdog_reset_req;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("reset request longer than one cycle");
  property p_off;
    watchdog_reset_req |-> $past(wd_on);
  endproperty
  a_off: assert property (p_off)
    else $error("reset request with watchdog off");
  property p_mode_read;
    (take && avs_read && avs_address == ADDR_MODE) |=> avs_readdata[6:4] == {en_reg, lk_reg, 1'b0};
  endproperty
  a_mode_read: assert property (p_mode_read)
    else $error("mode enable or lock bits read wrong");
  property p_run_read;
    (take && avs_read && avs_address == ADDR_CTRL) |=> avs_readdata[CTRL_RUN] == run_reg;
  endproperty
  a_run_read: assert property (p_run_read)
    else $error("run bit read wrong");
endmodule

// ---- tb/pca_compare_bench.sv ----
// Testbench for the counter array compare block
`timescale 1ns/1ps
module pca_compare_bench import pca_pkg::*;;
  logic            sys_clk = 1'b0;
  logic            sys_rst = 1'b1;
  logic [3:0]      avs_address = 4'h0;
  logic            avs_read = 1'b0;
  logic            avs_write = 1'b0;
  logic [31:0]     avs_writedata = 32'h0;
  logic [3:0]      avs_byteenable = 4'h0;
  logic [31:0]     avs_readdata;
  logic            avs_waitrequest;
  logic [NMOD-1:0] module_output_pin;
  logic            pca_irq;
  logic            watchdog_reset_req;
  int              errors = 0;
  int              compares = 0;
  int              cyc = 0;
  int              rq = 0;
  int              n;
  int              hi;
  int              tg;
  logic [7:0]      d;
  logic [15:0]     c;
  pca_compare uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cpu_idle(1'b0), .timer0_overflow(1'b0),
    .eci_pin(1'b1), .ext_clk_pin(1'b0), .module_output_pin(module_output_pin),
    .pca_irq(pca_irq), .watchdog_reset_req(watchdog_reset_req));
  initial forever #5 sys_clk = ~sys_clk;
  // ==========================================
  // Bus tasks and checks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] v);
    avs_address <= a;
    avs_writedata <= {24'h0, v};
    avs_byteenable <= 4'h1;
    avs_write <= w;
    avs_read <= ~w;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic watch(input int i);
    logic p;
    repeat (300) @(posedge sys_clk);
    hi = 0;
    tg = 0;
    p = module_output_pin[i];
    repeat (512)
    begin
      @(posedge sys_clk);
      hi += (module_output_pin[i] === 1'b1);
      tg += (module_output_pin[i] !== p);
      p = module_output_pin[i];
    end
  endtask
  task automatic give_verdict;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (watchdog_reset_req === 1'b1)
      rq <= rq + 1;
    if (cyc == 30000)
    begin
      errors++;
      give_verdict;
    end
  end
  // ==========================================
  // Scenarios
  initial
  begin
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    n = 0;
    while (rq == 0 && n < 4000)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk("timeout_window", 32'(n >= 3072 && n <= 3092), 32'h1);
    @(posedge sys_clk);
    chk("timeout_pulses", rq, 1);
    acc(0, ADDR_MODE, 8'h00);
    chk("mode_reset", d, 8'h40);
    sys_rst <= 1'b1;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    acc(0, ADDR_CTRL, 8'h00);
    chk("ctrl_reset", d, 8'h00);
    // Timebase bits are frozen while the watchdog runs: switch it off first
    acc(1, ADDR_MODE, 8'h00);
    acc(1, ADDR_MODE, 8'h08);
    acc(0, ADDR_MODE, 8'h00);
    chk("mode_off", d, 8'h08);
    acc(1, ADDR_MMODE, 8'h49);
    acc(1, ADDR_CMPL, 8'h20);
    acc(0, ADDR_MMODE, 8'h00);
    chk("low_clears_en", d, 8'h09);
    acc(1, ADDR_CMPH, 8'h00);
    acc(0, ADDR_MMODE, 8'h00);
    chk("high_sets_en", d, 8'h49);
    acc(1, ADDR_CTRL, 8'h40);
    n = 0;
    while (pca_irq !== 1'b1 && n < 300)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk("timer_irq", pca_irq, 1'b1);
    acc(0, ADDR_CTRL, 8'h00);
    chk("flag_held", d, 8'h41);
    acc(1, ADDR_CTRL, 8'h40);
    acc(0, ADDR_CTRL, 8'h00);
    chk("flag_cleared", d, 8'h40);
    acc(1, ADDR_MMODE + 4'h1, 8'h42);
    acc(1, ADDR_CMPL + 4'h1, 8'h80);
    acc(1, ADDR_CMPH + 4'h1, 8'h80);
    watch(1);
    chk("pwm8_high", hi, 256);
    acc(1, ADDR_CMPL + 4'h1, 8'h80);
    watch(1);
    chk("pwm8_zero", hi, 0);
    acc(1, ADDR_MMODE + 4'h2, 8'h46);
    acc(1, ADDR_CMPL + 4'h2, 8'h00);
    acc(1, ADDR_CMPH + 4'h2, 8'h10);
    watch(2);
    chk("freq_toggles", tg, 32);
    acc(1, ADDR_CMPH + 4'h2, 8'h00);
    watch(2);
    chk("freq_256", tg, 2);
    acc(1, ADDR_MMODE, 8'h4c);
    acc(0, ADDR_CNTL, 8'h00);
    c[7:0] = d;
    acc(0, ADDR_CNTH, 8'h00);
    c[15:8] = d;
    c = c + 16'h0040;
    acc(1, ADDR_CMPL, c[7:0]);
    acc(1, ADDR_CMPH, c[15:8]);
    chk("hso_entry", module_output_pin[0], 1'b1);
    repeat (64) @(posedge sys_clk);
    chk("hso_toggle", module_output_pin[0], 1'b0);
    acc(1, ADDR_CTRL, 8'h00);
    acc(1, ADDR_CNTL, 8'hc0);
    acc(1, ADDR_CNTH, 8'hff);
    acc(0, ADDR_CNTL, 8'h00);
    chk("cnt_stopped", d, 8'hc0);
    acc(1, ADDR_MMODE + 4'h1, 8'hcb);
    acc(1, ADDR_CMPL + 4'h1, 8'he0);
    acc(1, ADDR_CMPH + 4'h1, 8'hff);
    chk("pwm16_low", module_output_pin[1], 1'b0);
    acc(1, ADDR_CTRL, 8'h40);
    n = 0;
    while (pca_irq !== 1'b1 && n < 300)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk("pwm16_high", module_output_pin[1], 1'b1);
    acc(1, ADDR_CMPL + 4'h1, 8'h00);
    acc(1, ADDR_CMPH + 4'h1, 8'h80);
    repeat (40) @(posedge sys_clk);
    chk("pwm16_ovf", module_output_pin[1], 1'b0);
    acc(1, ADDR_MODE, 8'h48);
    acc(1, ADDR_CMPL + 4'h2, 8'h05);
    acc(1, ADDR_CMPH + 4'h2, 8'h77);
    acc(0, ADDR_CMPH + 4'h2, 8'h00);
    chk("wd_update", d, 8'h05);
    acc(1, ADDR_CNTH, 8'h80);
    acc(0, ADDR_CNTL, 8'h00);
    acc(0, ADDR_CNTH, 8'h00);
    chk("wd_cnt_locked", d, 8'h00);
    n = rq;
    acc(1, ADDR_CTRL, 8'h44);
    @(posedge sys_clk);
    chk("forced_reset", rq - n, 1);
    give_verdict;
  end
endmodule
bind pca_compare pca_compare_chk chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .module_output_pin(module_output_pin), .pca_irq(pca_irq),
  .watchdog_reset_req(watchdog_reset_req));
